// file: include/gcm_regs.svh
`ifndef GCM_REGS_SVH
`define GCM_REGS_SVH

// system clock rate
`define GCM_CLK_MHZ 100
// number of global clock selectors and quadrants
`define GCM_NUM_MUX 16
`define GCM_QUADS 4
// global nets one quadrant may carry
`define GCM_NETS_PER_QUAD 5'h08
// manager outputs that may reach global buffers at once
`define GCM_MAX_GLOBAL 5'h04
// number of manager clock outputs
`define GCM_NUM_OUTS 9
// fine phase steps per input period (phase accumulator high byte)
`define GCM_PHASE_STEPS 256
// cycles from reference pin edge to registered output
`define GCM_DESKEW_LAT 16'h0004
// quarter period offsets in accumulator units
`define GCM_Q90 16'h4000
`define GCM_Q180 16'h8000
`define GCM_Q270 16'hc000
// full period in accumulator units
`define GCM_FULL_PERIOD 32'h0001_0000
// matching periods counted before lock; the next matching period sets lock
`define GCM_LOCK_PERIODS 8
// reference periods per divided clock period
`define GCM_DV_DIV 4'h2
// input loss timeout, in ns, and as clock cycles
`define GCM_TIMEOUT_NS 10000
`define GCM_TIMEOUT_CYC ((`GCM_TIMEOUT_NS * `GCM_CLK_MHZ) / 1000)
// reset values
`define GCM_FINE_RST 8'h00
`define GCM_ROUTE_RST 9'h000

`endif

// file: include/gcm_pkg.sv
package gcm_pkg;

  // glitch-free selector states
  typedef enum logic [1:0] {
    GCM_RUN       = 2'b00,
    GCM_WAIT_LOW  = 2'b01,
    GCM_WAIT_FALL = 2'b10
  } gcm_mux_state_t;

  // synthesis configuration: output = input * mult / div
  typedef struct packed {
    logic [4:0] mult;
    logic [4:0] div;
    logic wait_lock;
  } gcm_cfg_t;

  // fine phase shift request
  typedef struct packed {
    logic en;
    logic inc;
  } gcm_ps_t;

  // the nine manager clock outputs
  typedef struct packed {
    logic base;
    logic q90;
    logic q180;
    logic q270;
    logic dbl;
    logic dbl_inv;
    logic divd;
    logic fx;
    logic fx_inv;
  } gcm_clks_t;

endpackage

// file: src/gcm_selector.sv
`timescale 1ns/100ps
`include "gcm_regs.svh"

module gcm_selector (
  input wire logic clk_i,            // system clock
  input wire logic nrst_i,           // async reset, active low
  input wire logic clock_input_a_i,  // first source clock pin
  input wire logic clock_input_b_i,  // second source clock pin
  input wire logic sel_i,            // high picks b, low picks a
  output logic clk_o                 // selected clock, registered
);
  import gcm_pkg::*;

  logic a_s1, a_s2, a_s3, b_s1, b_s2, b_s3, sel_s1, sel_s2;
  gcm_mux_state_t state_reg, state_next;
  logic cur_reg, cur_next, tgt_reg, tgt_next, out_reg, out_next;
  logic cur_lvl, tgt_fall;

  // pin synchronisers, third stage only for edge detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
      a_s3 <= 1'b0;
      b_s1 <= 1'b0;
      b_s2 <= 1'b0;
      b_s3 <= 1'b0;
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
    end else begin
      a_s1 <= clock_input_a_i;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      b_s1 <= clock_input_b_i;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
      sel_s1 <= sel_i;
      sel_s2 <= sel_s1;
    end
  end

  // level of the clock now passed, falling edge of the wanted one
  assign cur_lvl = cur_reg ? b_s2 : a_s2;
  assign tgt_fall = tgt_reg ? (b_s3 & ~b_s2) : (a_s3 & ~a_s2);

  // switchover sequence
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    tgt_next = tgt_reg;
    out_next = 1'b0;
    case (state_reg)
      GCM_RUN: begin
        out_next = cur_lvl;
        if (sel_s2 != cur_reg) begin
          tgt_next = sel_s2;
          if (cur_lvl) begin
            state_next = GCM_WAIT_LOW;
          end else begin
            state_next = GCM_WAIT_FALL;
          end
        end
      end
      GCM_WAIT_LOW: begin
        out_next = cur_lvl;
        if (sel_s2 == cur_reg) begin
          state_next = GCM_RUN;
        end else if (!cur_lvl) begin
          state_next = GCM_WAIT_FALL;
        end
      end
      GCM_WAIT_FALL: begin
        out_next = 1'b0;
        tgt_next = sel_s2;
        if (tgt_fall) begin
          cur_next = tgt_reg;
          state_next = GCM_RUN;
        end
      end
      default: begin
        state_next = GCM_WAIT_FALL;
      end
    endcase
  end

  // selector registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= GCM_RUN;
      cur_reg <= 1'b0;
      tgt_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      tgt_reg <= tgt_next;
      out_reg <= out_next;
    end
  end

  assign clk_o = out_reg;

endmodule

// file: src/gcm_top.sv
`timescale 1ns/100ps
`include "gcm_regs.svh"

// Overview of operation
// - each selector passes one input and switches without glitch or runt
// - select high picks second input, low picks first input
// - if passed clock is high at select change, pass it until low
// - once select changed and passed clock is low, hold output low
// - output stays low until the new clock falls
// - at the new clock's falling edge, output follows the new clock
// - works with unrelated clocks and select changing at any time
// - sixteen selectors, at most eight global nets per quadrant
// - manager outputs except fx and fx_inv phase aligned to reference, latency compensated
// - quarter, half and three-quarter period shifted copies provided
// - fine phase adjust in 1/256 period steps
// - fine phase changed at run time through shift control input
// - synthesised clock at integer or fractional multiple of input
// - at most four of nine outputs on global buffers at once
// - optionally hold configuration done until manager locks
module gcm_top #(
  parameter int NUM_MUX = `GCM_NUM_MUX,
  parameter int QUADS = `GCM_QUADS,
  parameter int LOCK_PERIODS = `GCM_LOCK_PERIODS,
  parameter int TIMEOUT_CYC = `GCM_TIMEOUT_CYC
) (
  input wire logic clk_i,                        // system clock
  input wire logic nrst_i,                       // async reset, low
  input wire logic [NUM_MUX-1:0] mux_clk_a_i,    // selector input a
  input wire logic [NUM_MUX-1:0] mux_clk_b_i,    // selector input b
  input wire logic [NUM_MUX-1:0] mux_sel_i,      // selector select
  output logic [NUM_MUX-1:0] mux_clk_o,          // global nets
  input wire logic [QUADS-1:0][NUM_MUX-1:0] quad_req_i, // net use
  output logic [QUADS-1:0][NUM_MUX-1:0] quad_net_o,     // granted nets
  output logic quad_err_o,                       // quadrant overuse
  input wire logic ref_clk_i,                    // manager reference
  input wire logic cm_rst_i,                     // manager reset, high
  input wire gcm_pkg::gcm_cfg_t cfg_i,           // synthesis config
  input wire gcm_pkg::gcm_ps_t ps_i,             // phase shift request
  output logic ps_done_o,                        // shift applied pulse
  output logic [7:0] fine_phase_o,               // fine phase offset
  output gcm_pkg::gcm_clks_t clks_o,             // manager clocks
  input wire logic [`GCM_NUM_OUTS-1:0] route_req_i, // global routing
  output logic [`GCM_NUM_OUTS-1:0] route_o,      // granted routing
  output logic route_err_o,                      // too many requested
  output logic locked_o,                         // manager locked
  input wire logic cfg_req_i,                    // config may finish
  output logic cfg_done_o                        // config complete
);
  import gcm_pkg::*;

  // count of set bits in a mask
  function automatic logic [4:0] ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // high half of a period at a given phase offset
  function automatic logic hi_at(input logic [15:0] p,
                                 input logic [15:0] off);
    logic [15:0] q;
    q = p - off;
    return ~q[15];
  endfunction

  // sixteen glitch-free selectors
  for (genvar g = 0; g < NUM_MUX; g++) begin : g_sel
    gcm_selector u_sel (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .clock_input_a_i(mux_clk_a_i[g]),
      .clock_input_b_i(mux_clk_b_i[g]),
      .sel_i(mux_sel_i[g]),
      .clk_o(mux_clk_o[g])
    );
  end

  // ---- global net and output routing grants
  logic [QUADS-1:0][NUM_MUX-1:0] quad_reg, quad_next;
  logic quad_err_reg, quad_err_next;
  logic [`GCM_NUM_OUTS-1:0] route_reg, route_next;
  logic route_err_reg, route_err_next;

  // an over-full request keeps the previous grant and flags it
  always_comb begin
    quad_next = quad_reg;
    quad_err_next = 1'b0;
    for (int q = 0; q < QUADS; q++) begin
      if (ones(quad_req_i[q]) <= `GCM_NETS_PER_QUAD) begin
        quad_next[q] = quad_req_i[q];
      end else begin
        quad_err_next = 1'b1;
      end
    end
    route_next = route_reg;
    route_err_next = 1'b0;
    if (ones({7'h00, route_req_i}) <= `GCM_MAX_GLOBAL) begin
      route_next = route_req_i;
    end else begin
      route_err_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quad_reg <= '0;
      quad_err_reg <= 1'b0;
      route_reg <= `GCM_ROUTE_RST;
      route_err_reg <= 1'b0;
    end else begin
      quad_reg <= quad_next;
      quad_err_reg <= quad_err_next;
      route_reg <= route_next;
      route_err_reg <= route_err_next;
    end
  end

  // ---- reference measurement and lock
  logic ref_s1, ref_s2, ref_s3, ref_rise;
  logic [15:0] cnt_reg, cnt_next, per_reg, per_next, meas;
  logic [15:0] step_reg, step_next;
  logic [7:0] stab_reg, stab_next;
  logic lock_reg, lock_next, lost;

  // reference pin synchroniser, third stage for edge detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else begin
      ref_s1 <= ref_clk_i;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  assign ref_rise = ref_s2 & ~ref_s3;
  assign meas = cnt_reg + 16'h0001;
  assign lost = (cnt_reg == 16'(TIMEOUT_CYC));

  // period counter, stability count and accumulator step
  always_comb begin
    cnt_next = lost ? cnt_reg : cnt_reg + 16'h0001;
    per_next = per_reg;
    stab_next = stab_reg;
    lock_next = lock_reg;
    step_next = (per_reg < 16'h0002) ? 16'h0000 :
                16'(`GCM_FULL_PERIOD / {16'h0000, per_reg});
    if (ref_rise) begin
      cnt_next = 16'h0000;
      per_next = meas;
      if ((meas == per_reg) || (meas == per_reg + 16'h0001) ||
          (meas + 16'h0001 == per_reg)) begin
        if (stab_reg != 8'hff) begin
          stab_next = stab_reg + 8'h01;
        end
        if (stab_reg >= 8'(LOCK_PERIODS)) begin
          lock_next = 1'b1;
        end
      end else begin
        stab_next = 8'h00;
        lock_next = 1'b0;
      end
    end
    if (cm_rst_i || lost) begin
      stab_next = 8'h00;
      lock_next = 1'b0;
    end
    if (cm_rst_i) begin
      per_next = 16'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 16'h0000;
      per_reg <= 16'h0000;
      step_reg <= 16'h0000;
      stab_reg <= 8'h00;
      lock_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      per_reg <= per_next;
      step_reg <= step_next;
      stab_reg <= stab_next;
      lock_reg <= lock_next;
    end
  end

  // ---- phase accumulators, fine shift and clock generation
  logic [15:0] ph_reg, ph_next, sp;
  logic [7:0] fine_reg, fine_next;
  logic done_reg, done_next, wrap_reg;
  logic [3:0] dv_reg, dv_next;
  logic [21:0] fx_reg, fx_next, fx_mod, fx_inc;
  logic [4:0] div_eff;
  gcm_clks_t clks_reg, clks_next;
  logic cfg_done_reg, cfg_done_next;

  assign sp = ph_reg + {fine_reg, 8'h00};
  assign div_eff = (cfg_i.div == 5'h00) ? 5'h01 : cfg_i.div;
  assign fx_mod = {1'b0, div_eff, 16'h0000};
  assign fx_inc = 22'(step_reg) * 22'(cfg_i.mult);

  always_comb begin
    ph_next = ph_reg + step_reg;
    if (ref_rise) begin
      ph_next = 16'(step_reg * `GCM_DESKEW_LAT);
    end
    fine_next = fine_reg;
    done_next = 1'b0;
    if (ps_i.en && lock_reg) begin
      fine_next = ps_i.inc ? fine_reg + 8'h01 : fine_reg - 8'h01;
      done_next = 1'b1;
    end
    dv_next = dv_reg;
    if (wrap_reg && !sp[15]) begin
      dv_next = (dv_reg + 4'h1 >= `GCM_DV_DIV) ? 4'h0 : dv_reg + 4'h1;
    end
    fx_next = fx_reg + fx_inc;
    if (fx_next >= fx_mod) begin
      fx_next = fx_next - fx_mod;
    end
    if (cm_rst_i) begin
      ph_next = 16'h0000;
      fine_next = `GCM_FINE_RST;
      dv_next = 4'h0;
      fx_next = 22'h000000;
    end
    clks_next.base = hi_at(sp, 16'h0000);
    clks_next.q90 = hi_at(sp, `GCM_Q90);
    clks_next.q180 = hi_at(sp, `GCM_Q180);
    clks_next.q270 = hi_at(sp, `GCM_Q270);
    clks_next.dbl = ~sp[14];
    clks_next.dbl_inv = sp[14];
    clks_next.divd = ({dv_reg, 1'b0} < {1'b0, `GCM_DV_DIV});
    clks_next.fx = (fx_reg < {1'b0, fx_mod[21:1]});
    clks_next.fx_inv = ~clks_next.fx;
    cfg_done_next = cfg_done_reg |
                    (cfg_req_i & (~cfg_i.wait_lock | lock_reg));
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_reg <= 16'h0000;
      fine_reg <= `GCM_FINE_RST;
      done_reg <= 1'b0;
      wrap_reg <= 1'b0;
      dv_reg <= 4'h0;
      fx_reg <= 22'h000000;
      clks_reg <= '0;
      cfg_done_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      fine_reg <= fine_next;
      done_reg <= done_next;
      wrap_reg <= sp[15];
      dv_reg <= dv_next;
      fx_reg <= fx_next;
      clks_reg <= clks_next;
      cfg_done_reg <= cfg_done_next;
    end
  end

  assign quad_net_o = quad_reg;
  assign quad_err_o = quad_err_reg;
  assign route_o = route_reg;
  assign route_err_o = route_err_reg;
  assign locked_o = lock_reg;
  assign ps_done_o = done_reg;
  assign fine_phase_o = fine_reg;
  assign clks_o = clks_reg;
  assign cfg_done_o = cfg_done_reg;

endmodule

// file: tb/gcm_checker.sv
`timescale 1ns/100ps
module gcm_checker #(
  parameter int TIMEOUT_CYC = 50
) (
  input wire logic clk_i,              // clock
  input wire logic nrst_i,             // reset, low
  input wire logic [15:0] mux_clk_o,   // nets
  input wire logic ref_clk_i,          // reference
  input wire logic cm_rst_i,           // manager reset
  input wire gcm_pkg::gcm_cfg_t cfg_i, // config
  input wire gcm_pkg::gcm_ps_t ps_i,   // shift request
  input wire logic ps_done_o,          // shift done
  input wire logic [7:0] fine_phase_o, // offset
  input wire logic [8:0] route_req_i,  // route request
  input wire logic [8:0] route_o,      // route grant
  input wire logic route_err_o,        // route error
  input wire logic locked_o,           // lock
  input wire logic cfg_req_i,          // config ready
  input wire logic cfg_done_o          // config done
);
  import gcm_pkg::*;
  logic ref_q_reg, ref_q_next;
  logic [11:0] idle_reg, idle_next;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // cycles since the reference pin last moved
  always_comb begin
    ref_q_next = ref_clk_i;
    idle_next = idle_reg;
    if (ref_clk_i != ref_q_reg) idle_next = 12'h000;
    else if (idle_reg != 12'hfff) idle_next = idle_reg + 12'h001;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_q_reg <= 1'b0;
      idle_reg <= 12'h000;
    end else begin
      ref_q_reg <= ref_q_next;
      idle_reg <= idle_next;
    end
  end
  // an accepted shift request
  sequence s_shift;
    ps_i.en && locked_o && !cm_rst_i;
  endsequence
  sequence s_step;
    ps_done_o && fine_phase_o ==
      $past(fine_phase_o) + ($past(ps_i.inc) ? 8'h01 : 8'hff);
  endsequence
  chk_route_cap: assert property ($countones(route_o) <= 4)
    else $error("route grant over four");
  chk_route_keep: assert property ($countones(route_req_i) > 4
    |=> route_err_o && $stable(route_o)) else $error("route not refused");
  chk_route_take: assert property ($countones(route_req_i) <= 4
    |=> !route_err_o && route_o == $past(route_req_i))
    else $error("route not granted");
  chk_ps_step: assert property (s_shift |=> s_step)
    else $error("phase step wrong");
  chk_ps_refuse: assert property (ps_i.en && !locked_o && !cm_rst_i
    |=> !ps_done_o && $stable(fine_phase_o)) else $error("shift taken");
  chk_lock_drop: assert property (cm_rst_i |=> !locked_o)
    else $error("lock kept over reset");
  chk_lock_loss: assert property (
    idle_reg > TIMEOUT_CYC + 4 |-> !locked_o)
    else $error("lock kept without input");
  chk_cfg_wait: assert property ($rose(cfg_done_o) |->
    $past(cfg_req_i) && (!$past(cfg_i.wait_lock) || $past(locked_o)))
    else $error("config done early");
  chk_cfg_hold: assert property (cfg_done_o |=> cfg_done_o)
    else $error("config done dropped");
  // every level on a selector output lasts at least two cycles
  for (genvar i = 0; i < 16; i++) begin : g_mux
    chk_mux_runt: assert property ($changed(mux_clk_o[i]) |->
      $past(mux_clk_o[i]) == $past(mux_clk_o[i], 2))
      else $error("runt pulse on selector");
  end
endmodule

bind gcm_top gcm_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk_i, .nrst_i, .mux_clk_o, .ref_clk_i, .cm_rst_i, .cfg_i, .ps_i,
  .ps_done_o, .fine_phase_o, .route_req_i, .route_o, .route_err_o,
  .locked_o, .cfg_req_i, .cfg_done_o
);

// file: tb/gcm_fabric_model.sv
`timescale 1ns/100ps
module gcm_fabric_model (
  input wire logic ref_en_i,    // let reference run
  output logic [15:0] clk_a_o,  // first source clocks
  output logic [15:0] clk_b_o,  // second source clocks
  output logic ref_clk_o        // manager reference
);
  // unrelated sources: 80 ns and 140 ns, odd offsets
  initial begin
    clk_a_o = 16'h0000;
    #3;
    forever #40 clk_a_o = ~clk_a_o;
  end
  initial begin
    clk_b_o = 16'h0000;
    #17.3;
    forever #70 clk_b_o = ~clk_b_o;
  end
  // 200 ns reference, stands low while disabled
  initial begin
    ref_clk_o = 1'b0;
    forever begin
      #100;
      ref_clk_o = ref_en_i ? ~ref_clk_o : 1'b0;
    end
  end
endmodule

// file: tb/test_gcm_top.sv
`timescale 1ns/100ps
module test_gcm_top;
  import gcm_pkg::*;
  logic clk_i, nrst_i, ref_clk_i, cm_rst_i, cfg_req_i, ref_en;
  logic [15:0] mux_clk_a_i, mux_clk_b_i, mux_sel_i, mux_clk_o;
  logic [3:0][15:0] quad_req_i, quad_net_o;
  logic quad_err_o, ps_done_o, route_err_o, locked_o, cfg_done_o;
  gcm_cfg_t cfg_i;
  gcm_ps_t ps_i;
  gcm_clks_t clks_o;
  logic [7:0] fine_phase_o;
  logic [8:0] route_req_i, route_o;
  int error_cnt = 0;
  int compares = 0;
  gcm_top #(.TIMEOUT_CYC(50)) dut (
    .clk_i, .nrst_i, .mux_clk_a_i, .mux_clk_b_i, .mux_sel_i, .mux_clk_o,
    .quad_req_i, .quad_net_o, .quad_err_o, .ref_clk_i, .cm_rst_i, .cfg_i,
    .ps_i, .ps_done_o, .fine_phase_o, .clks_o, .route_req_i, .route_o,
    .route_err_o, .locked_o, .cfg_req_i, .cfg_done_o
  );
  gcm_fabric_model u_fab (.ref_en_i(ref_en), .clk_a_o(mux_clk_a_i),
    .clk_b_o(mux_clk_b_i), .ref_clk_o(ref_clk_i));
  // clock generation
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic check_cnt(input string nm, input int e, g);
    compares++;
    if (g < e - 1 || g > e + 1) begin
      error_cnt++;
      $display("mismatch %s exp %0d got %0d", nm, e, g);
    end
  endtask
  // rising edges of one signal bit over n cycles
  task automatic rises(input int n, input int b, output int c);
    logic p, v;
    c = 0;
    p = (b < 0) ? mux_clk_o[0] : clks_o[b];
    repeat (n) begin
      tick(1);
      v = (b < 0) ? mux_clk_o[0] : clks_o[b];
      if (v === 1'b1 && p === 1'b0) c++;
      p = v;
    end
  endtask
  task automatic wait_lock();
    int k;
    for (k = 0; k < 1000 && locked_o !== 1'b1; k++) tick(1);
    check("locked", 16'h1, {15'h0, locked_o});
    if (k == 1000) close_out();
  endtask
  task automatic t_route();
    route_req_i = 9'h00f;
    tick(2);
    check("route", 16'h000f, {7'h0, route_o});
    route_req_i = 9'h1f0;
    tick(2);
    check("route kept", 16'h000f, {7'h0, route_o});
    check("route err", 16'h1, {15'h0, route_err_o});
    quad_req_i[2] = 16'h00ff;
    tick(2);
    check("quad", 16'h00ff, quad_net_o[2]);
    quad_req_i[2] = 16'h01ff;
    tick(2);
    check("quad kept", 16'h00ff, quad_net_o[2]);
    check("quad err", 16'h1, {15'h0, quad_err_o});
    $display("routing test done");
  endtask
  task automatic t_mux();
    int c;
    tick(30);
    rises(280, -1, c);
    check_cnt("mux a rises", 35, c);
    // flips at arbitrary spacing exercise the switch
    for (int i = 0; i < 8; i++) begin
      mux_sel_i = ~mux_sel_i;
      tick(5 + 3 * i);
    end
    mux_sel_i = 16'hffff;
    tick(40);
    rises(280, -1, c);
    check_cnt("mux b rises", 20, c);
    $display("selector test done");
  endtask
  task automatic t_lock();
    ps_i = '{en: 1'b1, inc: 1'b1};
    tick(1);
    ps_i.en = 1'b0;
    check("ps refused", 16'h0, {7'h0, ps_done_o, fine_phase_o});
    cfg_i = '{mult: 5'h03, div: 5'h02, wait_lock: 1'b1};
    cfg_req_i = 1'b1;
    ref_en = 1'b1;
    tick(3);
    check("cfg held", 16'h0, {15'h0, cfg_done_o});
    wait_lock();
    tick(2);
    check("cfg done", 16'h1, {15'h0, cfg_done_o});
    $display("lock test done");
  endtask
  task automatic t_shift();
    ps_i = '{en: 1'b1, inc: 1'b1};
    tick(1);
    check("ps done", 16'h1, {15'h0, ps_done_o});
    tick(2);
    check("fine up", 16'h0003, {8'h0, fine_phase_o});
    ps_i.inc = 1'b0;
    tick(4);
    ps_i.en = 1'b0;
    check("fine wrap", 16'h00ff, {8'h0, fine_phase_o});
    tick(1);
    check("ps idle", 16'h0, {15'h0, ps_done_o});
    $display("shift test done");
  endtask
  task automatic t_clocks();
    int ex[9] = '{12, 12, 4, 16, 16, 8, 8, 8, 8};
    int c;
    for (int b = 0; b < 9; b++) begin
      rises(160, b, c);
      check_cnt("clock rises", ex[b], c);
    end
    $display("clock test done");
  endtask
  task automatic t_loss();
    ref_en = 1'b0;
    tick(80);
    check("lock lost", 16'h0, {15'h0, locked_o});
    ref_en = 1'b1;
    wait_lock();
    cm_rst_i = 1'b1;
    tick(1);
    cm_rst_i = 1'b0;
    check("cm reset", 16'h0, {7'h0, locked_o, fine_phase_o});
    $display("loss test done");
  endtask
  // main sequence
  initial begin
    nrst_i = 1'b0;
    cm_rst_i = 1'b0;
    cfg_req_i = 1'b0;
    ref_en = 1'b0;
    mux_sel_i = 16'h0000;
    quad_req_i = '0;
    route_req_i = 9'h000;
    cfg_i = '{mult: 5'h01, div: 5'h01, wait_lock: 1'b1};
    ps_i = '{en: 1'b0, inc: 1'b0};
    tick(6);
    nrst_i = 1'b1;
    tick(1);
    t_route();
    t_mux();
    t_lock();
    t_shift();
    t_clocks();
    t_loss();
    close_out();
  end
endmodule
